// *** design/lsi_regs.vh ***
// Purpose: register offsets, field positions and reset values of the latched status block
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register
// Notes: status and info registers are 8 bits wide, the pending register is 24 bits
`ifndef LSI_REGS_VH
`define LSI_REGS_VH

`define LSI_ADDR_W 8
`define LSI_OFF_STATUS_ONE 8'h00
`define LSI_OFF_STATUS_TWO 8'h04
`define LSI_OFF_RX_INFO_ONE 8'h08
`define LSI_OFF_RX_INFO_TWO 8'h0C
`define LSI_OFF_RX_INFO_THREE 8'h10
`define LSI_OFF_HDLC_STATUS 8'h14
`define LSI_OFF_IRQ_MASK_ONE 8'h18
`define LSI_OFF_IRQ_MASK_TWO 8'h1C
`define LSI_OFF_HDLC_IRQ_MASK 8'h20
`define LSI_OFF_IRQ_PENDING 8'h24

// decoder codes: the six status/info registers first, in the order above
`define LSI_SEL_STATUS_ONE 4'h0
`define LSI_SEL_STATUS_TWO 4'h1
`define LSI_SEL_RX_INFO_ONE 4'h2
`define LSI_SEL_RX_INFO_TWO 4'h3
`define LSI_SEL_RX_INFO_THREE 4'h4
`define LSI_SEL_HDLC 4'h5
`define LSI_SEL_MASK_ONE 4'h6
`define LSI_SEL_MASK_TWO 4'h7
`define LSI_SEL_HDLC_MASK 4'h8
`define LSI_SEL_PENDING 4'h9
`define LSI_SEL_NONE 4'hF
`define LSI_NUM_STATUS 6

`define LSI_RESP_OKAY 2'b00
`define LSI_RESP_SLVERR 2'b10

`define LSI_BYTE_RST 8'h00
`define LSI_PEND_RST 24'h000000
`define LSI_WORD_RST 32'h00000000

// alarm inputs: 0 sync loss, 1 carrier loss, 2 blue alarm, 3 yellow alarm
`define LSI_ALM_SYNC 0
`define LSI_ALM_CARRIER 1
`define LSI_ALM_BLUE 2
`define LSI_NUM_ALARMS 4
`define LSI_NUM_SOURCES 45

`endif

// *** design/lsi_status_irq.v ***
// Purpose: latched status/info registers with mask-write, read, write-back access and interrupt
// Assumes: event and alarm sources are asynchronous levels; an event is a rising edge
// Notes: registers reached over AXI4-Lite; interrupt output is active low
`timescale 1ns/10ps
`include "lsi_regs.vh"
module lsi_status_irq (
   input wire aclk,
   input wire aresetn,
   input wire [`LSI_ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`LSI_ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [3:0] alarm_in,
   input wire [3:0] status_one_evt_in,
   input wire [7:0] status_two_evt_in,
   input wire [7:0] rx_info_one_evt_in,
   input wire [4:0] rx_info_two_evt_in,
   input wire [7:0] rx_info_three_evt_in,
   input wire [7:0] hdlc_evt_in,
   output reg irq_n
);
   // register number from a byte address; unmapped gives none
   function [3:0] reg_decode;
      input [`LSI_ADDR_W-1:0] addr;
      begin
         case (addr)
            `LSI_OFF_STATUS_ONE: reg_decode = `LSI_SEL_STATUS_ONE;
            `LSI_OFF_STATUS_TWO: reg_decode = `LSI_SEL_STATUS_TWO;
            `LSI_OFF_RX_INFO_ONE: reg_decode = `LSI_SEL_RX_INFO_ONE;
            `LSI_OFF_RX_INFO_TWO: reg_decode = `LSI_SEL_RX_INFO_TWO;
            `LSI_OFF_RX_INFO_THREE: reg_decode = `LSI_SEL_RX_INFO_THREE;
            `LSI_OFF_HDLC_STATUS: reg_decode = `LSI_SEL_HDLC;
            `LSI_OFF_IRQ_MASK_ONE: reg_decode = `LSI_SEL_MASK_ONE;
            `LSI_OFF_IRQ_MASK_TWO: reg_decode = `LSI_SEL_MASK_TWO;
            `LSI_OFF_HDLC_IRQ_MASK: reg_decode = `LSI_SEL_HDLC_MASK;
            `LSI_OFF_IRQ_PENDING: reg_decode = `LSI_SEL_PENDING;
            default: reg_decode = `LSI_SEL_NONE;
         endcase
      end
   endfunction

   wire [`LSI_NUM_SOURCES-1:0] src_lvl;
   wire [`LSI_NUM_SOURCES-1:0] src_rise;
   wire [`LSI_NUM_SOURCES-1:0] src_fall;

   lsi_sync_edge #(
      .WIDTH(`LSI_NUM_SOURCES)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({
         hdlc_evt_in,
         rx_info_three_evt_in,
         rx_info_two_evt_in,
         rx_info_one_evt_in,
         status_two_evt_in,
         status_one_evt_in,
         alarm_in
      }),
      .level_reg(src_lvl),
      .rise_reg(src_rise),
      .fall_reg(src_fall)
   );

   // per-register set vectors; alarm bits are set every cycle the alarm stands
   wire [7:0] set_status_one = {src_rise[7:4], src_lvl[3:0]};
   wire [7:0] set_status_two = src_rise[15:8];
   wire [7:0] set_rx_info_one = src_rise[23:16];
   // recovery bits of rx_info_two come from alarm falls, the rest from plain events
   wire [7:0] set_rx_info_two = {
      src_fall[`LSI_ALM_SYNC],
      src_fall[`LSI_ALM_CARRIER],
      src_rise[28:26],
      src_fall[`LSI_ALM_BLUE],
      src_rise[25:24]
   };
   wire [7:0] set_rx_info_three = src_rise[36:29];
   wire [7:0] set_hdlc = src_rise[44:37];
   wire [47:0] set_all = {set_hdlc, set_rx_info_three, set_rx_info_two, set_rx_info_one,
      set_status_two, set_status_one};

   // alarms raise a source on both edges, everything else on occurrence
   wire [3:0] alarm_change = src_rise[3:0] | src_fall[3:0];
   wire [23:0] pend_set = {set_hdlc, set_status_two, src_rise[7:4], alarm_change};

   // latch holds what hardware saw, view what a read returns, fresh what a read may clear
   // pending keeps a source until released, whatever its mask, so unmasking shows it
   reg [47:0] latch_reg, latch_next;
   reg [47:0] view_reg, view_next;
   reg [47:0] fresh_reg, fresh_next;
   reg [23:0] pend_reg, pend_next;
   reg [7:0] mask_one_reg;
   reg [7:0] mask_two_reg;
   reg [7:0] mask_hdlc_reg;
   reg aw_held_reg;
   reg w_held_reg;
   reg [`LSI_ADDR_W-1:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;

   wire [31:0] strobe_bits = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
      {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   wire [31:0] w_val = w_data_reg & strobe_bits;
   // a write executes once address and data are both held and the last answer is gone
   wire wr_do = aw_held_reg && w_held_reg && !s_axi_bvalid;
   wire [3:0] wr_sel = reg_decode(aw_addr_reg);
   wire rd_do = s_axi_arvalid && s_axi_arready;
   wire [3:0] rd_sel = reg_decode(s_axi_araddr);
   wire [23:0] irq_mask = {mask_hdlc_reg, mask_two_reg, mask_one_reg};

   reg [47:0] rd_clr;
   reg [23:0] pend_clr;
   integer k;

   always @* begin
      rd_clr = 48'h000000000000;
      fresh_next = fresh_reg;
      view_next = view_reg;
      pend_clr = `LSI_PEND_RST;
      // a read clears the bits it showed as one among those just refreshed
      for (k = 0; k < `LSI_NUM_STATUS; k = k + 1) begin
         if (rd_do && rd_sel == k[3:0]) begin
            rd_clr[k*8 +: 8] = view_reg[k*8 +: 8] & fresh_reg[k*8 +: 8];
            fresh_next[k*8 +: 8] = 8'h00;
         end
      end
      // reading a refreshed source bit releases its interrupt, whatever its value
      if (rd_do && rd_sel == `LSI_SEL_STATUS_ONE) begin
         pend_clr[7:0] = fresh_reg[7:0];
      end
      if (rd_do && rd_sel == `LSI_SEL_STATUS_TWO) begin
         pend_clr[15:8] = fresh_reg[15:8];
      end
      if (rd_do && rd_sel == `LSI_SEL_HDLC) begin
         pend_clr[23:16] = fresh_reg[47:40];
      end
      // mask write: ones refresh the view, zeros hold it
      for (k = 0; k < `LSI_NUM_STATUS; k = k + 1) begin
         if (wr_do && wr_sel == k[3:0]) begin
            view_next[k*8 +: 8] = (view_reg[k*8 +: 8] & ~w_val[7:0]) |
               (latch_reg[k*8 +: 8] & w_val[7:0]);
            fresh_next[k*8 +: 8] = fresh_next[k*8 +: 8] | w_val[7:0];
         end
      end
      if (wr_do && wr_sel == `LSI_SEL_PENDING) begin
         pend_clr = pend_clr | w_val[23:0];
      end
      // hardware set wins over any clear in the same cycle
      latch_next = (latch_reg & ~rd_clr) | set_all;
      pend_next = (pend_reg & ~pend_clr) | pend_set;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         latch_reg <= 48'h000000000000;
         view_reg <= 48'h000000000000;
         fresh_reg <= 48'h000000000000;
         pend_reg <= `LSI_PEND_RST;
         mask_one_reg <= `LSI_BYTE_RST;
         mask_two_reg <= `LSI_BYTE_RST;
         mask_hdlc_reg <= `LSI_BYTE_RST;
         irq_n <= 1'b1;
      end else begin
         latch_reg <= latch_next;
         view_reg <= view_next;
         fresh_reg <= fresh_next;
         pend_reg <= pend_next;
         // masks gate only the pin; latching and reading go on regardless
         irq_n <= ~|(pend_next & irq_mask);
         if (wr_do && wr_sel == `LSI_SEL_MASK_ONE) begin
            mask_one_reg <= w_val[7:0];
         end
         if (wr_do && wr_sel == `LSI_SEL_MASK_TWO) begin
            mask_two_reg <= w_val[7:0];
         end
         if (wr_do && wr_sel == `LSI_SEL_HDLC_MASK) begin
            mask_hdlc_reg <= w_val[7:0];
         end
      end
   end

   // write channels: address and data are taken independently, answer follows both
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `LSI_RESP_OKAY;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= {`LSI_ADDR_W{1'b0}};
         w_data_reg <= `LSI_WORD_RST;
         w_strb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_do) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (wr_sel == `LSI_SEL_NONE) begin
               s_axi_bresp <= `LSI_RESP_SLVERR;
            end else begin
               s_axi_bresp <= `LSI_RESP_OKAY;
            end
         end
         // ready again only after the answer is taken, so one write at a time
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // read word and response, picked from the current views, masks or pending bits; unused upper bits stay zero
   reg [31:0] rd_word;
   reg rd_err;

   always @* begin
      rd_word = `LSI_WORD_RST;
      rd_err = 1'b0;
      case (rd_sel)
         `LSI_SEL_STATUS_ONE: rd_word[7:0] = view_reg[7:0];
         `LSI_SEL_STATUS_TWO: rd_word[7:0] = view_reg[15:8];
         `LSI_SEL_RX_INFO_ONE: rd_word[7:0] = view_reg[23:16];
         `LSI_SEL_RX_INFO_TWO: rd_word[7:0] = view_reg[31:24];
         `LSI_SEL_RX_INFO_THREE: rd_word[7:0] = view_reg[39:32];
         `LSI_SEL_HDLC: rd_word[7:0] = view_reg[47:40];
         `LSI_SEL_MASK_ONE: rd_word[7:0] = mask_one_reg;
         `LSI_SEL_MASK_TWO: rd_word[7:0] = mask_two_reg;
         `LSI_SEL_HDLC_MASK: rd_word[7:0] = mask_hdlc_reg;
         `LSI_SEL_PENDING: rd_word[23:0] = pend_reg;
         default: rd_err = 1'b1;
      endcase
   end

   // read channel: data is captured at the address edge, side effects happen there too
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `LSI_WORD_RST;
         s_axi_rresp <= `LSI_RESP_OKAY;
      end else begin
         if (rd_do) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            if (rd_err) begin
               s_axi_rresp <= `LSI_RESP_SLVERR;
            end else begin
               s_axi_rresp <= `LSI_RESP_OKAY;
            end
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // lsi_status_irq

// *** design/lsi_sync_edge.v ***
// Purpose: two-stage synchroniser bank with level, rise and fall outputs
// Assumes: inputs are asynchronous levels; a pulse shorter than one clock may be missed
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module lsi_sync_edge #(
   parameter WIDTH = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] level_reg,
   output reg [WIDTH-1:0] rise_reg,
   output reg [WIDTH-1:0] fall_reg
);
   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] stable_reg;

   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= {WIDTH{1'b0}};
         stable_reg <= {WIDTH{1'b0}};
         level_reg <= {WIDTH{1'b0}};
         rise_reg <= {WIDTH{1'b0}};
         fall_reg <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= async_in;
         stable_reg <= meta_reg;
         level_reg <= stable_reg;
         rise_reg <= stable_reg & ~level_reg;
         fall_reg <= ~stable_reg & level_reg;
      end
   end
endmodule // lsi_sync_edge

// *** tb/lsi_host.sv ***
// Purpose: host model reaching the status block over AXI4-Lite
// Assumes: one transfer at a time; bready and rready stay high
// Notes: poll keeps the mask-write, read, write-back order
`timescale 1ns/10ps
module lsi_host (
   input wire aclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} <= '0;
      {s_axi_araddr, s_axi_arvalid} <= '0;
      s_axi_wstrb <= 4'hF;
      s_axi_bready <= 1'b1;
      s_axi_rready <= 1'b1;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
   endtask
   // write-back of read AND mask refreshes the shown bits from the latch, so bits seen as one clear unless an event raced the read or their alarm stands
   task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
      logic [1:0] r;
      logic [31:0] x;
      wr(a, {24'h000000, m}, r);
      rd(a, x);
      d = x[7:0];
      wr(a, {24'h000000, d & m}, r);
   endtask
endmodule // lsi_host

// *** tb/lsi_status_irq_checker.sv ***
// Purpose: bus and interrupt properties of the latched status block
// Assumes: single clock, synchronous active-low reset
// Notes: interrupt release must follow a finished bus access
`timescale 1ns/10ps
module lsi_status_irq_checker (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire irq_n
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   chk_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
   chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
      && !s_axi_arready) else $error("read answer late");
   chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   chk_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
      else $error("upper read bits set");
   chk_irq_release: assert property ($rose(irq_n) |-> s_axi_rvalid || s_axi_bvalid
      || $past(s_axi_rvalid) || $past(s_axi_bvalid) || !$past(aresetn))
      else $error("interrupt released without access");
   chk_b_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
      && s_axi_awready && s_axi_wready) else $error("write side not reopened");
   chk_r_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
      && s_axi_arready) else $error("read side not reopened");
endmodule // lsi_status_irq_checker
bind lsi_status_irq lsi_status_irq_checker lsi_status_irq_checker_i (.*);

// *** tb/lsi_status_irq_test.sv ***
// Purpose: self-checking bench for the latched status and interrupt block
// Assumes: host model runs the bus; event inputs are driven here
// Notes: inputs are held 8 clocks so the synchronisers see them
`timescale 1ns/10ps
`include "lsi_regs.vh"
module lsi_status_irq_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [3:0] alarm_in = 4'h0, status_one_evt_in = 4'h0;
   logic [7:0] status_two_evt_in = 8'h00, rx_info_one_evt_in = 8'h00;
   logic [7:0] rx_info_three_evt_in = 8'h00, hdlc_evt_in = 8'h00;
   logic [4:0] rx_info_two_evt_in = 5'h00;
   wire [7:0] s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0] s_axi_wstrb;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_n;
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [7:0] d;
   logic [31:0] x;
   logic [1:0] r;
   lsi_status_irq lsi_status_irq_i (.*);
   lsi_host lsi_host_i (.*);
   always #20 aclk = ~aclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic settle;
      repeat (8) @(posedge aclk);
   endtask
   task automatic t_regs;
      lsi_host_i.rd(`LSI_OFF_IRQ_MASK_ONE, x);
      chk(x, `LSI_WORD_RST);
      chk(s_axi_rresp, `LSI_RESP_OKAY);
      lsi_host_i.rd(8'h40, x);
      chk(x, `LSI_WORD_RST);
      chk(s_axi_rresp, `LSI_RESP_SLVERR);
      lsi_host_i.wr(8'h40, 32'h000000FF, r);
      chk(r, `LSI_RESP_SLVERR);
      lsi_host_i.wr(`LSI_OFF_IRQ_MASK_ONE, 32'h000000FF, r);
      chk(r, `LSI_RESP_OKAY);
      lsi_host_i.rd(`LSI_OFF_IRQ_MASK_ONE, x);
      chk(x, 32'h000000FF);
      lsi_host_i.wr(`LSI_OFF_HDLC_IRQ_MASK, 32'h00000003, r);
   endtask
   task automatic t_alarms;
      for (int i = 0; i < 4; i++) begin
         chk(irq_n, 1'b1);
         alarm_in[i] <= 1'b1;
         settle();
         chk(irq_n, 1'b0);
         lsi_host_i.poll(`LSI_OFF_STATUS_ONE, 8'h01 << i, d);
         chk(d & (8'h01 << i), 8'h01 << i);
         chk(irq_n, 1'b1);
         lsi_host_i.poll(`LSI_OFF_STATUS_ONE, 8'h01 << i, d);
         chk(d & (8'h01 << i), 8'h01 << i);
      end
      alarm_in <= 4'h0;
      settle();
      chk(irq_n, 1'b0);
      lsi_host_i.poll(`LSI_OFF_RX_INFO_TWO, 8'hC0, d);
      chk(d, 8'hC0);
      lsi_host_i.poll(`LSI_OFF_STATUS_ONE, 8'h0F, d);
      chk(irq_n, 1'b1);
   endtask
   task automatic t_events;
      status_one_evt_in <= 4'h8;
      settle();
      status_one_evt_in <= 4'h0;
      settle();
      chk(irq_n, 1'b0);
      lsi_host_i.poll(`LSI_OFF_STATUS_ONE, 8'h80, d);
      chk(d & 8'h80, 8'h80);
      chk(irq_n, 1'b1);
      lsi_host_i.poll(`LSI_OFF_STATUS_ONE, 8'h80, d);
      chk(d & 8'h80, 8'h00);
      hdlc_evt_in <= 8'h01;
      settle();
      chk(irq_n, 1'b0);
      lsi_host_i.poll(`LSI_OFF_HDLC_STATUS, 8'h01, d);
      chk(d, 8'h01);
      chk(irq_n, 1'b1);
      hdlc_evt_in <= 8'h03;
      settle();
      chk(irq_n, 1'b0);
      lsi_host_i.wr(`LSI_OFF_IRQ_PENDING, 32'h00020000, r);
      chk(irq_n, 1'b1);
   endtask
   task automatic t_masked;
      status_two_evt_in <= 8'h20;
      rx_info_one_evt_in <= 8'hFF;
      rx_info_three_evt_in <= 8'hFF;
      settle();
      chk(irq_n, 1'b1);
      lsi_host_i.poll(`LSI_OFF_RX_INFO_THREE, 8'hFF, d);
      chk(d, 8'hFF);
      lsi_host_i.wr(`LSI_OFF_STATUS_TWO, 32'h00000020, r);
      lsi_host_i.rd(`LSI_OFF_STATUS_TWO, x);
      chk(x, 32'h00000020);
      lsi_host_i.wr(`LSI_OFF_STATUS_TWO, 32'h00000000, r);
      lsi_host_i.rd(`LSI_OFF_STATUS_TWO, x);
      chk(x, 32'h00000020);
      lsi_host_i.wr(`LSI_OFF_STATUS_TWO, 32'h00000020, r);
      lsi_host_i.rd(`LSI_OFF_STATUS_TWO, x);
      chk(x, 32'h00000000);
      lsi_host_i.wr(`LSI_OFF_IRQ_MASK_TWO, 32'h00000020, r);
      status_two_evt_in <= 8'h00;
      settle();
      chk(irq_n, 1'b1);
      status_two_evt_in <= 8'h20;
      settle();
      chk(irq_n, 1'b0);
      lsi_host_i.poll(`LSI_OFF_STATUS_TWO, 8'h20, d);
      chk(d, 8'h20);
      chk(irq_n, 1'b1);
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_alarms();
      t_events();
      t_masked();
      end_of_test();
   end
endmodule // lsi_status_irq_test
